// [src/tsp_pkg.sv]
package tsp_pkg;

  localparam int REG_W = 8;
  localparam int ADDR_W = 12;

  // Byte addresses of the register words
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_DUTY = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_PHASE = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h020;

  // Field positions
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_PRESC_LSB = 0;
  localparam int FLAG_PERIOD_BIT = 1;
  localparam int MODE_ROLE_LSB = 6;
  localparam int MODE_AUX_BIT = 5;
  localparam int STAT_PWM_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_SYNC_BIT = 2;
  localparam int STAT_DUTY_LSB = 8;
  localparam int STAT_PHASE_LSB = 16;

  // Values after reset
  localparam logic [REG_W-1:0] COUNT_RST = 8'h00;
  localparam logic [REG_W-1:0] PERIOD_RST = 8'hFF;
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] IRQ_EN_RST = 8'h00;
  localparam logic [REG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [REG_W-1:0] MODE_RST = 8'h00;
  localparam logic [REG_W-1:0] DUTY_RST = 8'h00;
  localparam logic [REG_W-1:0] PHASE_RST = 8'h00;

  // Prescaler terminal counts, factor minus one
  localparam logic [3:0] PRESC_MAX_1 = 4'h0;
  localparam logic [3:0] PRESC_MAX_4 = 4'h3;
  localparam logic [3:0] PRESC_MAX_8 = 4'h7;
  localparam logic [3:0] PRESC_MAX_16 = 4'hF;

  typedef enum logic [1:0] {
    ROLE_ALONE = 2'b00,
    ROLE_MASTER = 2'b01,
    ROLE_RSVD = 2'b10,
    ROLE_SLAVE = 2'b11
  } tsp_role_e;

  typedef enum logic {
    PH_RUN = 1'b0,
    PH_WAIT = 1'b1
  } tsp_phase_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } tsp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tsp_apb_rsp_s;

endpackage

// [src/tsp_top.sv]
`timescale 1ns/1ps
module tsp_top (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire tsp_pkg::tsp_apb_req_s I_APB,
  output tsp_pkg::tsp_apb_rsp_s O_APB,
  input wire logic I_SLEEP,
  input wire logic I_SYNC_PIN,
  output logic O_SYNC_PIN,
  output logic O_SYNC_PIN_OE,
  output logic O_SYS_CLK
);
  import tsp_pkg::*;

  function automatic logic [3:0] presc_max(input logic [1:0] sel);
    case (sel)
      2'b00: presc_max = PRESC_MAX_1;
      2'b01: presc_max = PRESC_MAX_4;
      2'b10: presc_max = PRESC_MAX_8;
      default: presc_max = PRESC_MAX_16;
    endcase
  endfunction

  logic run;
  logic [1:0] presc_sel;
  logic [REG_W-1:0] count;
  logic [REG_W-1:0] period;
  logic [REG_W-1:0] irq_en;
  logic period_flag;
  logic [1:0] role_bits;
  logic mode_aux;
  logic [REG_W-1:0] duty_buf;
  logic [REG_W-1:0] phase_buf;
  logic [REG_W-1:0] duty_active;
  logic [REG_W-1:0] phase_active;
  logic [REG_W-1:0] phase_cnt;
  tsp_phase_e ph_state;
  logic [3:0] pre_cnt;
  logic pwm;
  logic sync_oe;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic sync_lvl;
  logic sync_lvl_d;
  logic [31:0] rd_data;

  // Bus decode
  wire setup_phase = I_APB.psel && !I_APB.penable;
  wire access_phase = I_APB.psel && I_APB.penable;
  wire wr_en = access_phase && I_APB.pwrite;
  wire hit_ctrl = I_APB.paddr == ADDR_CTRL;
  wire hit_count = I_APB.paddr == ADDR_COUNT;
  wire hit_period = I_APB.paddr == ADDR_PERIOD;
  wire hit_irq_en = I_APB.paddr == ADDR_IRQ_EN;
  wire hit_flags = I_APB.paddr == ADDR_IRQ_FLAGS;
  wire hit_mode = I_APB.paddr == ADDR_MODE;
  wire hit_duty = I_APB.paddr == ADDR_DUTY;
  wire hit_phase = I_APB.paddr == ADDR_PHASE;
  wire hit_status = I_APB.paddr == ADDR_STATUS;
  wire hit_any = hit_ctrl || hit_count || hit_period || hit_irq_en || hit_flags
                 || hit_mode || hit_duty || hit_phase || hit_status;
  wire wr_ctrl = wr_en && hit_ctrl;
  wire wr_count = wr_en && hit_count;
  wire wr_period = wr_en && hit_period;
  wire wr_irq_en = wr_en && hit_irq_en;
  wire wr_flags = wr_en && hit_flags;
  wire wr_mode = wr_en && hit_mode;
  wire wr_duty = wr_en && hit_duty;
  wire wr_phase = wr_en && hit_phase;
  wire [REG_W-1:0] wdata = I_APB.pwdata[REG_W-1:0];

  // Timer and sync role decode
  tsp_role_e role;
  assign role = tsp_role_e'(role_bits);
  wire is_slave = role == ROLE_SLAVE;
  wire is_master = role == ROLE_MASTER;
  wire active = run && !I_SLEEP;
  wire tick = pre_cnt == presc_max(presc_sel);
  wire adv = active && tick;
  wire match = count == period;
  wire adv_run = adv && (ph_state == PH_RUN);
  wire own_wrap = adv_run && match;
  wire master_edge = is_slave && active && sync_lvl && !sync_lvl_d;
  wire restart = own_wrap || master_edge;
  wire slave_wait = is_slave && (phase_buf != 8'h00);
  wire [REG_W-1:0] count_inc = count + 8'h01;
  wire phase_done = adv && (ph_state == PH_WAIT) && (phase_cnt == 8'h01);

  // Read mux
  wire [31:0] rd_ctrl = {24'h00_0000, 5'b00000, run, presc_sel};
  wire [31:0] rd_flags = {24'h00_0000, 6'b000000, period_flag, 1'b0};
  wire [31:0] rd_mode = {24'h00_0000, role_bits, mode_aux, 5'b00000};
  wire [31:0] rd_status = {8'h00, phase_active, duty_active, 5'b00000, sync_lvl,
                           ph_state == PH_WAIT, pwm};
  wire [31:0] next_rd_data = hit_ctrl ? rd_ctrl :
                             hit_count ? {24'h00_0000, count} :
                             hit_period ? {24'h00_0000, period} :
                             hit_irq_en ? {24'h00_0000, irq_en} :
                             hit_flags ? rd_flags :
                             hit_mode ? rd_mode :
                             hit_duty ? {24'h00_0000, duty_buf} :
                             hit_phase ? {24'h00_0000, phase_buf} :
                             hit_status ? rd_status : 32'h0000_0000;

  assign O_APB.prdata = rd_data;
  assign O_APB.pready = 1'b1;
  assign O_APB.pslverr = access_phase && !hit_any;
  assign O_SYS_CLK = pwm;
  assign O_SYNC_PIN = pwm;
  assign O_SYNC_PIN_OE = sync_oe;

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_data <= 32'h0000_0000;
    end else if (setup_phase && !I_APB.pwrite) begin
      rd_data <= next_rd_data;
    end
  end

  // Software registers
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      run <= CTRL_RST[CTRL_RUN_BIT];
      presc_sel <= CTRL_RST[CTRL_PRESC_LSB +: 2];
      period <= PERIOD_RST;
      irq_en <= IRQ_EN_RST;
      role_bits <= MODE_RST[MODE_ROLE_LSB +: 2];
      mode_aux <= MODE_RST[MODE_AUX_BIT];
      duty_buf <= DUTY_RST;
      phase_buf <= PHASE_RST;
    end else begin
      if (wr_ctrl) begin
        run <= wdata[CTRL_RUN_BIT];
        presc_sel <= wdata[CTRL_PRESC_LSB +: 2];
      end
      if (wr_period) period <= wdata;
      if (wr_irq_en) irq_en <= wdata;
      if (wr_mode) begin
        role_bits <= wdata[MODE_ROLE_LSB +: 2];
        mode_aux <= wdata[MODE_AUX_BIT];
      end
      if (wr_duty) duty_buf <= wdata;
      if (wr_phase) phase_buf <= wdata;
    end
  end

  // Match flag: a match in the clearing cycle keeps it set
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      period_flag <= FLAGS_RST[FLAG_PERIOD_BIT];
    end else begin
      period_flag <= own_wrap || (wr_flags ? wdata[FLAG_PERIOD_BIT] : period_flag);
    end
  end

  // Prescaler
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pre_cnt <= 4'h0;
    end else if (wr_ctrl || wr_count || master_edge) begin
      pre_cnt <= 4'h0;
    end else if (active) begin
      pre_cnt <= tick ? 4'h0 : pre_cnt + 4'h1;
    end
  end

  // Counter; control writes do not touch it
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      count <= COUNT_RST;
    end else if (wr_count) begin
      count <= wdata;
    end else if (restart) begin
      count <= COUNT_RST;
    end else if (adv_run) begin
      count <= count_inc;
    end
  end

  // Double-buffered duty and phase
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      duty_active <= DUTY_RST;
      phase_active <= PHASE_RST;
    end else if (restart) begin
      duty_active <= duty_buf;
      if (is_slave) phase_active <= phase_buf;
    end
  end

  // Slave phase delay counted in prescaler ticks
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ph_state <= PH_RUN;
      phase_cnt <= 8'h00;
    end else begin
      case (ph_state)
        PH_RUN: begin
          if (restart && slave_wait) begin
            ph_state <= PH_WAIT;
            phase_cnt <= phase_buf;
          end
        end
        PH_WAIT: begin
          if (master_edge && slave_wait) begin
            phase_cnt <= phase_buf;
          end else if (master_edge) begin
            ph_state <= PH_RUN;
          end else if (phase_done) begin
            ph_state <= PH_RUN;
          end else if (adv) begin
            phase_cnt <= phase_cnt - 8'h01;
          end
        end
        default: ph_state <= PH_RUN;
      endcase
    end
  end

  // Output level
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pwm <= 1'b0;
    end else if (restart) begin
      pwm <= !slave_wait && (duty_buf != 8'h00);
    end else if (phase_done) begin
      pwm <= duty_active != 8'h00;
    end else if (adv_run && count_inc == duty_active) begin
      pwm <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync_oe <= 1'b0;
    end else begin
      sync_oe <= is_master;
    end
  end

  // Sync pin input: three stages, change taken when stages two and three agree
  // Reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync_s1 <= 1'b1;
      sync_s2 <= 1'b1;
      sync_s3 <= 1'b1;
      sync_lvl <= 1'b1;
      sync_lvl_d <= 1'b1;
    end else begin
      sync_s1 <= I_SYNC_PIN;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      if (sync_s2 == sync_s3) sync_lvl <= sync_s3;
      sync_lvl_d <= sync_lvl;
    end
  end

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  property p_wrap;
    own_wrap && !wr_count |=> count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not return to zero after match");

  property p_inc;
    adv_run && !match && !wr_count && !restart |=> count == $past(count) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not advance on tick");

  property p_flag;
    own_wrap |=> period_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("match flag not set");

  property p_flag_clear;
    wr_flags && !wdata[FLAG_PERIOD_BIT] && !own_wrap |=> !period_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("match flag not cleared by write");

  property p_stopped;
    !run && !wr_count && !master_edge ##1 !wr_count |-> $stable(count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_presc_clr;
    (wr_ctrl || wr_count) |=> pre_cnt == 4'h0;
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared by write");

  property p_ctrl_keeps;
    wr_ctrl && !adv && !restart |=> count == $past(count);
  endproperty
  a_ctrl_keeps: assert property (p_ctrl_keeps) else $error("control write changed counter");

  property p_div4;
    run && presc_sel == 2'b01 && adv && !I_SLEEP ##1 (run && presc_sel == 2'b01 && !I_SLEEP
      && !wr_ctrl && !wr_count && !master_edge) [*3] |-> !adv;
  endproperty
  a_div4: assert property (p_div4) else $error("prescale by four ticked early");

  property p_duty_load;
    restart |=> duty_active == $past(duty_buf);
  endproperty
  a_duty_load: assert property (p_duty_load) else $error("duty not loaded at restart");

  property p_phase_load;
    restart && is_slave |=> phase_active == $past(phase_buf);
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("phase not loaded at restart");

  property p_duty_hold;
    !restart |=> duty_active == $past(duty_active);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("active duty changed between matches");

  property p_sleep;
    I_SLEEP && !wr_count |=> $stable(pwm) && count == $past(count);
  endproperty
  a_sleep: assert property (p_sleep) else $error("state changed during sleep");

  property p_ctrl_read;
    setup_phase && !I_APB.pwrite && hit_ctrl |=> rd_data[7:3] == 5'b00000;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("unimplemented control bits read nonzero");

  property p_master_oe;
    is_master ##1 is_master |-> O_SYNC_PIN_OE && O_SYNC_PIN == O_SYS_CLK;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("master not driving sync pin");

  property p_slave_wait;
    restart && slave_wait |=> ph_state == PH_WAIT && !pwm;
  endproperty
  a_slave_wait: assert property (p_slave_wait) else $error("slave did not delay cycle start");

  property p_phase_rise;
    phase_done && !restart |=> pwm == ($past(duty_active) != 8'h00);
  endproperty
  a_phase_rise: assert property (p_phase_rise) else $error("slave output did not start after phase");

  property p_fall;
    adv_run && !restart && count_inc == duty_active |=> !pwm;
  endproperty
  a_fall: assert property (p_fall) else $error("output did not fall at duty");

  c_wrap: cover property (own_wrap);
  c_slave_sync: cover property (master_edge && slave_wait ##[1:300] phase_done);
  c_flag_race: cover property (own_wrap && wr_flags);
  c_sleep: cover property (active ##1 I_SLEEP ##1 !I_SLEEP);

endmodule

// [sim/tsp_peer.sv]
`timescale 1ns/1ps
module tsp_peer (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [7:0] i_per,
  input wire logic [7:0] i_hi,
  output logic o_drv,
  output logic o_oe
);
  logic [7:0] cnt;

  // Master system clock onto the shared pin; released pin floats to pull-up
  always_ff @(posedge i_clk) begin
    if (!i_en) begin
      cnt <= 8'h00;
      o_oe <= 1'b0;
      o_drv <= 1'b1;
    end else begin
      o_oe <= 1'b1;
      o_drv <= (cnt < i_hi);
      cnt <= (cnt == i_per - 8'h01) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule

// [sim/tsp_top_test.sv]
`timescale 1ns/1ps
module tsp_top_test;
  import tsp_pkg::*;
  typedef struct packed {
    logic w;
    logic [ADDR_W-1:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic err;
  } tsp_row_s;
  logic clk, rstn, sleep, peer_en, peer_drv, peer_oe, sync_o, sync_oe, sys_clk, sync_wire;
  tsp_apb_req_s apb;
  tsp_apb_rsp_s rsp;
  int n_mismatch = 0;
  int check_count = 0;
  int n, hi, lo, d0, d1;
  int fac [4] = '{1, 4, 8, 16};
  logic [31:0] rd;
  logic er;
  logic [7:0] cnt_a;
  logic lvl;
  tsp_row_s rows [22] = '{
    '{1'b0, ADDR_CTRL, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_COUNT, 8'h00, 8'h00, 1'b0},
    '{1'b0, ADDR_PERIOD, 8'h00, 8'hFF, 1'b0}, '{1'b0, ADDR_IRQ_EN, 8'h00, 8'h00, 1'b0},
    '{1'b0, ADDR_IRQ_FLAGS, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_MODE, 8'h00, 8'h00, 1'b0},
    '{1'b0, ADDR_DUTY, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_PHASE, 8'h00, 8'h00, 1'b0},
    '{1'b1, ADDR_CTRL, 8'hFF, 8'h00, 1'b0}, '{1'b0, ADDR_CTRL, 8'h00, 8'h07, 1'b0},
    '{1'b1, ADDR_CTRL, 8'h00, 8'h00, 1'b0}, '{1'b1, ADDR_COUNT, 8'h33, 8'h00, 1'b0},
    '{1'b1, ADDR_CTRL, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_COUNT, 8'h00, 8'h33, 1'b0},
    '{1'b1, ADDR_PERIOD, 8'h5A, 8'h00, 1'b0}, '{1'b0, ADDR_PERIOD, 8'h00, 8'h5A, 1'b0},
    '{1'b1, ADDR_IRQ_EN, 8'hA5, 8'h00, 1'b0}, '{1'b0, ADDR_IRQ_EN, 8'h00, 8'hA5, 1'b0},
    '{1'b1, ADDR_MODE, 8'hA0, 8'h00, 1'b0}, '{1'b0, ADDR_MODE, 8'h00, 8'hA0, 1'b0},
    '{1'b1, 12'h040, 8'h55, 8'h00, 1'b1}, '{1'b0, 12'h040, 8'h00, 8'h00, 1'b1}};

  assign sync_wire = sync_oe ? sync_o : ((peer_oe === 1'b1) ? peer_drv : 1'b1);

  tsp_top dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_APB(apb), .O_APB(rsp), .I_SLEEP(sleep),
    .I_SYNC_PIN(sync_wire), .O_SYNC_PIN(sync_o), .O_SYNC_PIN_OE(sync_oe), .O_SYS_CLK(sys_clk));
  tsp_peer peer (.i_clk(clk), .i_en(peer_en), .i_per(8'h64), .i_hi(8'h32), .o_drv(peer_drv), .o_oe(peer_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d}};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 100);
    if (k >= 100) n_mismatch++;
    q = rsp.prdata;
    e = rsp.pslverr;
    apb <= '0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, rd, er);
  endtask

  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    while (sys_clk !== v && c < 5000) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 5000) n_mismatch++;
  endtask

  // Cycles from a master clock rise to the slave output rise
  task automatic gap(output int d);
    while (peer_drv !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    while (peer_drv !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    wait_lvl(1'b1, d);
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    sleep = 1'b0;
    peer_en = 1'b0;
    apb = '0;
    repeat (20) @(posedge clk);
    chk(32'({sys_clk, sync_oe, sync_o}), 32'h0000_0000);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].w) chk(rd, 32'(rows[i].e));
      chk(32'(er), 32'(rows[i].err));
    end
    // Stopped timer, then flag clear and set
    repeat (20) @(posedge clk);
    bus(1'b0, ADDR_COUNT, 8'h00, rd, er);
    chk(rd, 32'h0000_0033);
    wr(ADDR_PERIOD, 8'h03);
    wr(ADDR_DUTY, 8'h01);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    bus(1'b0, ADDR_IRQ_FLAGS, 8'h00, rd, er);
    chk(rd, 32'h0000_0000);
    wr(ADDR_CTRL, 8'h04);
    repeat (10) @(posedge clk);
    bus(1'b0, ADDR_IRQ_FLAGS, 8'h00, rd, er);
    chk(rd, 32'h0000_0002);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, 8'(4 + c));
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      chk(32'(hi), 32'(fac[c]));
      chk(32'(hi + lo), 32'(4 * fac[c]));
    end
    // New duty waits for the next wrap
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wr(ADDR_DUTY, 8'h02);
    bus(1'b0, ADDR_STATUS, 8'h00, rd, er);
    chk(32'(rd[15:8]), 32'h0000_0001);
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    chk(32'(hi), 32'h0000_0020);
    // Sleep freezes count and output
    @(posedge clk);
    sleep <= 1'b1;
    bus(1'b0, ADDR_COUNT, 8'h00, rd, er);
    cnt_a = rd[7:0];
    lvl = sys_clk;
    repeat (100) @(posedge clk);
    bus(1'b0, ADDR_COUNT, 8'h00, rd, er);
    chk(rd, 32'(cnt_a));
    chk(32'(sys_clk), 32'(lvl));
    sleep <= 1'b0;
    // Master drives its system clock onto the pin
    wr(ADDR_MODE, 8'h40);
    repeat (2) @(posedge clk);
    repeat (80) begin
      @(posedge clk);
      #1;
      chk(32'({sync_oe, sync_o}), 32'({1'b1, sys_clk}));
    end
    // Slave follows the peer with a phase offset
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_PERIOD, 8'hFF);
    wr(ADDR_DUTY, 8'h08);
    wr(ADDR_PHASE, 8'h00);
    wr(ADDR_MODE, 8'hC0);
    peer_en <= 1'b1;
    gap(d0);
    gap(d0);
    chk(32'(sync_oe), 32'h0000_0000);
    wr(ADDR_PHASE, 8'h04);
    gap(d1);
    gap(d1);
    chk(32'(d1 - d0), 32'h0000_0004);
    bus(1'b0, ADDR_STATUS, 8'h00, rd, er);
    chk(32'(rd[23:8]), 32'h0000_0408);
    // Reset in mid-run restores counter, period and output
    wr(ADDR_PERIOD, 8'h40);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, ADDR_COUNT, 8'h00, rd, er);
    chk(rd, 32'h0000_0000);
    bus(1'b0, ADDR_PERIOD, 8'h00, rd, er);
    chk(rd, 32'h0000_00FF);
    chk(32'(sys_clk), 32'h0000_0000);
    summarize();
  end
endmodule
